// File: include/dpbram_pkg.sv
// Functional notes
// - array holds 256 words of 16 bits, one write port and one read port
// - on the active port edge the write port registers location, data and mask, the read port only its location
// - mask bit 0 writes the data bit, mask bit 1 keeps the stored bit
// - 8-bit write location picks which of 256 words is written
// - 8-bit read location picks which of 256 words reaches the read word
// - write port acts on rising write clock edge, falling edge selectable
// - read port acts on rising read clock edge, falling edge selectable
// - contents may be preloaded while configuration runs, before user access
// - rom use: preload contents and hold write controls inactive
// - location zero is never written by the preload
`default_nettype none

package dpbram_pkg;

    // ************************************************************
    // array geometry
    // ************************************************************
    localparam int WORDS      = 256;
    localparam int WORD_W     = 16;
    localparam int LOC_W      = 8;

    // ************************************************************
    // field values and reset values
    // ************************************************************
    localparam logic       MASK_KEEP    = 1'h1;
    localparam logic [7:0] PRELOAD_SKIP = 8'h00;
    localparam logic [15:0] WORD_RESET  = 16'h0000;

    // ************************************************************
    // port pin sampling
    // ************************************************************
    localparam int PORTS      = 2;
    localparam int WR_PORT    = 0;
    localparam int RD_PORT    = 1;
    localparam int CLK_PERIOD_NS = 100;

endpackage

`default_nettype wire

// File: verilog/dpbram_top.sv
`default_nettype none

module dpbram_top #(
    parameter int WORDS  = dpbram_pkg::WORDS,
    parameter int WORD_W = dpbram_pkg::WORD_W,
    parameter int LOC_W  = dpbram_pkg::LOC_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // configuration preload
    input  wire logic              cfgBusy,
    input  wire logic              cfgWe,
    input  wire logic [LOC_W-1:0]  cfgLocation,
    input  wire logic [WORD_W-1:0] cfgWord,
    // edge options and rom lock
    input  wire logic              wrFallEdge,
    input  wire logic              rdFallEdge,
    input  wire logic              romLock,
    // write port
    input  wire logic              wrClk,
    input  wire logic              wrClkEn,
    input  wire logic              wrStrobe,
    input  wire logic [LOC_W-1:0]  wrLocation,
    input  wire logic [WORD_W-1:0] wrWord,
    input  wire logic [WORD_W-1:0] wrMask,
    // read port
    input  wire logic              rdClk,
    input  wire logic              rdClkEn,
    input  wire logic              rdStrobe,
    input  wire logic [LOC_W-1:0]  rdLocation,
    output logic      [WORD_W-1:0] rdWord
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic [WORD_W-1:0] mem [WORDS];

    logic [dpbram_pkg::PORTS-1:0] pinRaw;
    logic [dpbram_pkg::PORTS-1:0] fallSel;
    logic [dpbram_pkg::PORTS-1:0] sync1_ff;
    logic [dpbram_pkg::PORTS-1:0] sync2_ff;
    logic [dpbram_pkg::PORTS-1:0] sync3_ff;
    logic [dpbram_pkg::PORTS-1:0] level_ff;
    logic [dpbram_pkg::PORTS-1:0] primed_ff;
    logic [dpbram_pkg::PORTS-1:0] portEdge;

    logic              wrTake;
    logic              rdTake;
    logic              preload;
    logic              wrGo_ff;
    logic [LOC_W-1:0]  wrLoc_ff;
    logic [WORD_W-1:0] wrWord_ff;
    logic [WORD_W-1:0] wrMask_ff;
    logic              rdGo_ff;
    logic [LOC_W-1:0]  rdLoc_ff;
    logic [WORD_W-1:0] rdWord_ff;
    logic [WORD_W-1:0] wrMerged;

    assign pinRaw[dpbram_pkg::WR_PORT]  = wrClk;
    assign pinRaw[dpbram_pkg::RD_PORT]  = rdClk;
    assign fallSel[dpbram_pkg::WR_PORT] = wrFallEdge;
    assign fallSel[dpbram_pkg::RD_PORT] = rdFallEdge;

    // ************************************************************
    // port clock pins: three stages, edge once stages two and three agree
    // ************************************************************
    for (genvar p = 0; p < dpbram_pkg::PORTS; p++) begin : g_port
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                sync1_ff[p] <= 1'h0;
                sync2_ff[p] <= 1'h0;
                sync3_ff[p] <= 1'h0;
            end else begin
                sync1_ff[p] <= pinRaw[p];
                sync2_ff[p] <= sync1_ff[p];
                sync3_ff[p] <= sync2_ff[p];
            end
        end

        // first agreement after reset only loads the level, no edge
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                level_ff[p]  <= 1'h0;
                primed_ff[p] <= 1'h0;
            end else if (sync2_ff[p] == sync3_ff[p]) begin
                level_ff[p]  <= sync3_ff[p];
                primed_ff[p] <= 1'h1;
            end
        end

        // active edge: new level differs from the falling-edge select
        assign portEdge[p] = primed_ff[p]
                           && (sync2_ff[p] == sync3_ff[p])
                           && (sync3_ff[p] != level_ff[p])
                           && (sync3_ff[p] != fallSel[p]);
    end

    // ************************************************************
    // write port capture
    // ************************************************************
    // user writes blocked while configuring and under rom lock
    assign wrTake = portEdge[dpbram_pkg::WR_PORT] && wrStrobe
                  && wrClkEn && !cfgBusy && !romLock;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrGo_ff <= 1'h0;
        end else begin
            wrGo_ff <= wrTake;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrLoc_ff  <= '0;
            wrWord_ff <= dpbram_pkg::WORD_RESET;
            wrMask_ff <= '1;
        end else if (wrTake) begin
            wrLoc_ff  <= wrLocation;
            wrWord_ff <= wrWord;
            wrMask_ff <= wrMask;
        end
    end

    // ************************************************************
    // array: preload during configuration, then masked user writes
    // ************************************************************
    assign preload = cfgBusy && cfgWe
                   && (cfgLocation != dpbram_pkg::PRELOAD_SKIP);

    // kept bits take the stored value, the rest the captured word
    for (genvar b = 0; b < WORD_W; b++) begin : g_bit
        assign wrMerged[b] = (wrMask_ff[b] == dpbram_pkg::MASK_KEEP)
                           ? mem[wrLoc_ff][b] : wrWord_ff[b];
    end

    always_ff @(posedge clk) begin
        if (preload) begin
            mem[cfgLocation] <= cfgWord;
        end else if (wrGo_ff) begin
            mem[wrLoc_ff] <= wrMerged;
        end
    end

    // ************************************************************
    // read port capture and fetch
    // ************************************************************
    assign rdTake = portEdge[dpbram_pkg::RD_PORT] && rdStrobe
                  && rdClkEn && !cfgBusy;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdGo_ff  <= 1'h0;
            rdLoc_ff <= '0;
        end else begin
            rdGo_ff <= rdTake;
            if (rdTake) begin
                rdLoc_ff <= rdLocation;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdWord_ff <= dpbram_pkg::WORD_RESET;
        end else if (rdGo_ff) begin
            rdWord_ff <= mem[rdLoc_ff];
        end
    end

    assign rdWord = rdWord_ff;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    wr_edge_sel_a: assert property (
        portEdge[dpbram_pkg::WR_PORT] && $stable(wrFallEdge)
        |=> level_ff[dpbram_pkg::WR_PORT] != wrFallEdge)
        else $error("write port acted on the wrong edge");

    rd_edge_sel_a: assert property (
        portEdge[dpbram_pkg::RD_PORT] && $stable(rdFallEdge)
        |=> level_ff[dpbram_pkg::RD_PORT] != rdFallEdge)
        else $error("read port acted on the wrong edge");

    wr_gate_a: assert property (
        wrGo_ff |-> $past(portEdge[dpbram_pkg::WR_PORT]
                          && wrStrobe && wrClkEn))
        else $error("write started without edge, strobe and enable");

    rom_lock_a: assert property (
        romLock |=> !wrGo_ff)
        else $error("write started while rom lock held");

    wr_capture_a: assert property (
        wrTake |=> wrLoc_ff == $past(wrLocation)
                   && wrWord_ff == $past(wrWord))
        else $error("write location or data not captured");

    wr_masked_a: assert property (
        wrGo_ff && !preload
        |=> mem[$past(wrLoc_ff)] ==
            (($past(mem[wrLoc_ff]) & $past(wrMask_ff))
             | ($past(wrWord_ff) & ~$past(wrMask_ff))))
        else $error("masked write stored a wrong word");

    preload_word_a: assert property (
        preload |=> mem[$past(cfgLocation)] == $past(cfgWord))
        else $error("preload word not stored");

    preload_skip_a: assert property (
        cfgBusy && cfgWe && cfgLocation == dpbram_pkg::PRELOAD_SKIP
        && !wrGo_ff |=> $stable(mem[dpbram_pkg::PRELOAD_SKIP]))
        else $error("preload touched location zero");

    rd_fetch_a: assert property (
        rdTake |=> ##1 rdWord == $past(mem[rdLoc_ff]))
        else $error("read word does not match selected location");

    rd_hold_a: assert property (
        !rdGo_ff |=> $stable(rdWord))
        else $error("read word changed without a read");

    // ************************************************************
    // capture and gating checks
    // ************************************************************
    rd_gate_a: assert property (
        rdGo_ff |-> $past(portEdge[dpbram_pkg::RD_PORT]
                          && rdStrobe && rdClkEn && !cfgBusy))
        else $error("read started without edge, strobe and enable");

    rd_capture_a: assert property (
        rdTake
        |=> rdLoc_ff == $past(rdLocation))
        else $error("read location not captured");

    wr_mask_cap_a: assert property (
        wrTake
        |=> wrMask_ff == $past(wrMask))
        else $error("write mask not captured");

    wr_hold_a: assert property (
        !wrTake
        |=> $stable(wrLoc_ff) && $stable(wrWord_ff) && $stable(wrMask_ff))
        else $error("write capture changed without a take");

    rd_loc_hold_a: assert property (
        !rdTake
        |=> $stable(rdLoc_ff))
        else $error("read location changed without a take");

    wr_block_a: assert property (
        cfgBusy || romLock
        |-> !wrTake)
        else $error("write taken while configuring or locked");

    rd_block_a: assert property (
        cfgBusy
        |-> !rdTake)
        else $error("read taken while configuring");

    wr_edge_once_a: assert property (
        portEdge[dpbram_pkg::WR_PORT]
        |=> !portEdge[dpbram_pkg::WR_PORT])
        else $error("write pin edge seen twice");

    rd_edge_once_a: assert property (
        portEdge[dpbram_pkg::RD_PORT]
        |=> !portEdge[dpbram_pkg::RD_PORT])
        else $error("read pin edge seen twice");

    wr_go_once_a: assert property (
        wrGo_ff
        |=> !wrGo_ff)
        else $error("one write edge gave two writes");

    rd_go_once_a: assert property (
        rdGo_ff
        |=> !rdGo_ff)
        else $error("one read edge gave two fetches");

    wr_go_follow_a: assert property (
        wrTake
        |=> wrGo_ff)
        else $error("taken write not started");

    rd_go_follow_a: assert property (
        rdTake
        |=> rdGo_ff)
        else $error("taken read not started");

    rd_word_upd_a: assert property (
        rdGo_ff
        |=> rdWord == $past(mem[rdLoc_ff]))
        else $error("read word not loaded from read location");

    wr_word_upd_a: assert property (
        wrGo_ff && !preload && wrMask_ff == '0
        |=> mem[$past(wrLoc_ff)] == $past(wrWord_ff))
        else $error("unmasked write not stored at write location");

endmodule

`default_nettype wire

// File: tb/dpbram_user.sv
`default_nettype none

module dpbram_user (
    // clock and edge options
    input  wire logic        clk,
    input  wire logic        wrFallEdge,
    input  wire logic        rdFallEdge,
    // write port
    output logic             wrClk,
    output logic             wrClkEn,
    output logic             wrStrobe,
    output logic [7:0]       wrLocation,
    output logic [15:0]      wrWord,
    output logic [15:0]      wrMask,
    // read port
    output logic             rdClk,
    output logic             rdClkEn,
    output logic             rdStrobe,
    output logic [7:0]       rdLocation
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {wrClk, wrClkEn, wrStrobe, rdClk, rdClkEn, rdStrobe} = 6'h00;
        {wrLocation, wrWord, wrMask, rdLocation} = 48'h0;
    end

    // ************************************************************
    // strobe valid only around the configured active pin edge
    // ************************************************************
    task automatic wr(input logic [7:0] loc, input logic [15:0] d,
                      input logic [15:0] m, input logic en, input logic st);
        @(posedge clk);
        wrLocation <= loc;
        wrWord <= d;
        wrMask <= m;
        wrClkEn <= en;
        wrStrobe <= st & ~wrFallEdge;
        @(posedge clk);
        wrClk <= 1'h1;
        repeat (4) @(posedge clk);
        wrStrobe <= st & wrFallEdge;
        wrClk <= 1'h0;
        repeat (8) @(posedge clk);
        wrClkEn <= 1'h0;
        wrStrobe <= 1'h0;
        wrLocation <= ~loc;
        wrWord <= ~d;
        wrMask <= ~m;
    endtask

    task automatic rd(input logic [7:0] loc, input logic en,
                      input logic st);
        @(posedge clk);
        rdLocation <= loc;
        rdClkEn <= en;
        rdStrobe <= st & ~rdFallEdge;
        @(posedge clk);
        rdClk <= 1'h1;
        repeat (4) @(posedge clk);
        rdStrobe <= st & rdFallEdge;
        rdClk <= 1'h0;
        repeat (8) @(posedge clk);
        rdClkEn <= 1'h0;
        rdStrobe <= 1'h0;
        rdLocation <= ~loc;
    endtask
endmodule

`default_nettype wire

// File: tb/dpbram_tb.sv
`default_nettype none

module dpbram_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk = 1'h0;
    logic        nrst = 1'h0;
    logic        cfgBusy = 1'h0;
    logic        cfgWe = 1'h0;
    logic [7:0]  cfgLocation = 8'h00;
    logic [15:0] cfgWord = 16'h0000;
    logic        wrFallEdge = 1'h0;
    logic        rdFallEdge = 1'h0;
    logic        romLock = 1'h0;
    logic        wrClk, wrClkEn, wrStrobe, rdClk, rdClkEn, rdStrobe;
    logic [7:0]  wrLocation, rdLocation;
    logic [15:0] wrWord, wrMask, rdWord;
    int          num_errors = 0;
    int          num_checks = 0;

    always #50 clk = ~clk;

    dpbram_top uut (.clk(clk), .nrst(nrst), .cfgBusy(cfgBusy), .cfgWe(cfgWe),
        .cfgLocation(cfgLocation), .cfgWord(cfgWord),
        .wrFallEdge(wrFallEdge), .rdFallEdge(rdFallEdge), .romLock(romLock),
        .wrClk(wrClk), .wrClkEn(wrClkEn), .wrStrobe(wrStrobe),
        .wrLocation(wrLocation), .wrWord(wrWord), .wrMask(wrMask),
        .rdClk(rdClk), .rdClkEn(rdClkEn), .rdStrobe(rdStrobe),
        .rdLocation(rdLocation), .rdWord(rdWord));

    dpbram_user user (.clk(clk), .wrFallEdge(wrFallEdge),
        .rdFallEdge(rdFallEdge), .wrClk(wrClk), .wrClkEn(wrClkEn),
        .wrStrobe(wrStrobe), .wrLocation(wrLocation), .wrWord(wrWord),
        .wrMask(wrMask), .rdClk(rdClk), .rdClkEn(rdClkEn),
        .rdStrobe(rdStrobe), .rdLocation(rdLocation));

    // ************************************************************
    // shared checks
    // ************************************************************
    task automatic check(input string nm, input logic [15:0] exp,
                         input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask

    task automatic rchk(input logic [7:0] loc, input logic [15:0] exp,
                        input logic en, input logic st);
        user.rd(loc, en, st);
        check("rdWord", exp, rdWord);
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_preload();
        user.wr(8'h00, 16'h1234, 16'h0000, 1'h1, 1'h1);
        @(posedge clk);
        cfgBusy <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cfgWe <= 1'h1;
            cfgLocation <= 8'(i);
            cfgWord <= 16'ha5a0 + 16'(i);
        end
        @(posedge clk);
        cfgWe <= 1'h0;
        cfgBusy <= 1'h0;
        rchk(8'h00, 16'h1234, 1'h1, 1'h1);
        rchk(8'h03, 16'ha5a3, 1'h1, 1'h1);
    endtask

    task automatic t_mask();
        user.wr(8'hff, 16'hffff, 16'h0000, 1'h1, 1'h1);
        user.wr(8'hff, 16'h0000, 16'h00ff, 1'h1, 1'h1);
        rchk(8'hff, 16'h00ff, 1'h1, 1'h1);
        rchk(8'h01, 16'ha5a1, 1'h1, 1'h1);
    endtask

    task automatic t_gate();
        user.wr(8'hff, 16'h1111, 16'h0000, 1'h0, 1'h1);
        user.wr(8'hff, 16'h2222, 16'h0000, 1'h1, 1'h0);
        rchk(8'hff, 16'h00ff, 1'h1, 1'h1);
        rchk(8'h02, 16'h00ff, 1'h0, 1'h1);
        rchk(8'h02, 16'h00ff, 1'h1, 1'h0);
        cfgBusy <= 1'h1;
        rchk(8'h01, 16'h00ff, 1'h1, 1'h1);
        cfgBusy <= 1'h0;
    endtask

    task automatic t_rom();
        @(posedge clk);
        romLock <= 1'h1;
        user.wr(8'hff, 16'habcd, 16'h0000, 1'h1, 1'h1);
        romLock <= 1'h0;
        rchk(8'hff, 16'h00ff, 1'h1, 1'h1);
    endtask

    task automatic t_fall();
        @(posedge clk);
        wrFallEdge <= 1'h1;
        rdFallEdge <= 1'h1;
        user.wr(8'h80, 16'h5a5a, 16'h0000, 1'h1, 1'h1);
        rchk(8'h80, 16'h5a5a, 1'h1, 1'h1);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'h1;
        repeat (6) @(posedge clk);
        check("rdWord", 16'h0000, rdWord);
        t_preload();
        t_mask();
        t_gate();
        t_rom();
        t_fall();
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule

`default_nettype wire
